// *** bench/event_source_model.sv ***
`timescale 1ns/1ps
module event_source_model (
   // Clock
   input  wire logic        hclk,
   // Toward the bank
   output      logic [79:0] source_events
);
   initial source_events = '0;
   // Called just after an edge; n edges of high level
   task automatic fire(input int s, input int n);
      source_events[s] <= 1'b1;
      repeat (n) @(posedge hclk);
      source_events[s] <= 1'b0;
   endtask : fire
endmodule : event_source_model

// *** bench/irq_bank_sva.sv ***
`timescale 1ns/1ps
module irq_bank_sva (
   // Clock and reset
   input wire logic         hclk,
   input wire logic         hresetn,
   // Bus
   input wire logic         hsel,
   input wire logic [1:0]   htrans,
   input wire logic         hwrite,
   input wire logic         hready,
   input wire logic         hreadyout,
   input wire logic [31:0]  hrdata,
   // Sources
   input wire logic         can_present,
   input wire logic [79:0]  source_events,
   input wire logic [79:0]  source_req,
   input wire logic [239:0] source_prio,
   input wire logic         irq
);
   localparam logic [79:0] LIVE = 80'h007E_6000_601F_FFDF_7FFF;
   localparam logic [79:0] CAN  = 80'h0040_0000_000C_0000_0000;
   logic take;
   logic ev_any;
   logic wr_q;
   assign take   = hsel & htrans[1] & hready;
   assign ev_any = |source_events;
   // Write data phase: the only time software changes state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         wr_q <= 1'b0;
      else
         wr_q <= take & hwrite;
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence rd_wait;
      !hreadyout ##1 hreadyout;
   endsequence
   sequence caused;
      $past(ev_any) || $past(wr_q);
   endsequence
   a_read_wait:
      assert property (take && !hwrite |=> rd_wait)
      else $error("read data phase not two cycles");
   a_write_fast:
      assert property (take && hwrite |=> hreadyout)
      else $error("write data phase stalled");
   a_upper_zero:
      assert property (hrdata[31:16] == 16'h0000)
      else $error("upper read data not zero");
   a_dead_quiet:
      assert property ((source_req & ~LIVE) == '0)
      else $error("request from unimplemented position");
   a_can_quiet:
      assert property (!can_present |-> (source_req & CAN) == '0)
      else $error("request from absent controller");
   a_req_rise:
      assert property (|(source_req & ~$past(source_req)) |-> caused)
      else $error("request rose without event or write");
   a_req_hold:
      assert property (|($past(source_req) & ~source_req) |-> $past(wr_q))
      else $error("request dropped without write");
   a_irq_rise:
      assert property ($rose(irq) |-> caused)
      else $error("irq rose without cause");
   a_prio_reset:
      assert property ($rose(hresetn) |-> source_prio == {80{3'h4}})
      else $error("priority not four after reset");
endmodule : irq_bank_sva

bind irq_flag_enable_bank irq_bank_sva chk (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
   .hreadyout(hreadyout), .hrdata(hrdata), .can_present(can_present),
   .source_events(source_events), .source_req(source_req),
   .source_prio(source_prio), .irq(irq));

// *** bench/test_interrupt_flag_enable_bank.sv ***
`timescale 1ns/1ps
module test_interrupt_flag_enable_bank;
   logic         hclk;
   logic         hresetn;
   logic         hsel;
   logic         hwrite;
   logic         can_present;
   logic [1:0]   htrans;
   logic [31:0]  haddr;
   logic [31:0]  hwdata;
   logic [31:0]  hrdata;
   logic         hreadyout;
   logic         hresp;
   logic         irq;
   logic [79:0]  source_events;
   logic [79:0]  source_req;
   logic [239:0] source_prio;
   logic [15:0]  rd;
   int           fails;
   int           total_checks;
   localparam logic [15:0] LIVE [5] =
      '{16'h7FFF, 16'hFFDF, 16'h601F, 16'h6000, 16'h007E};
   localparam logic [79:0] LIVE_ALL =
      {LIVE[4], LIVE[3], LIVE[2], LIVE[1], LIVE[0]};

   irq_flag_enable_bank uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hresp), .can_present(can_present),
      .source_events(source_events), .source_req(source_req),
      .source_prio(source_prio), .irq(irq));
   event_source_model evm (.hclk(hclk), .source_events(source_events));

   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end

   task automatic check(input logic [79:0] seen, input logic [79:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // One single transfer; ev >= 0 fires that source in the data phase
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [15:0] d, input int ev);
      haddr <= {24'h000000, a};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (!hreadyout);
      htrans <= 2'h0;
      hwdata <= {16'h0000, d};
      if (ev >= 0) begin
         fork
            evm.fire(ev, 1);
         join_none
      end
      do @(posedge hclk); while (!hreadyout);
      rd = hrdata[15:0];
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      bus(1'b1, a, d, -1);
   endtask : wr

   task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
      bus(1'b0, a, 16'h0000, -1);
      check(80'(rd), 80'(exp));
      check(80'(hresp), 80'h0);
   endtask : rdc

   task automatic do_reset;
      hresetn <= 1'b0;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
   endtask : do_reset

   task automatic t_reset;
      for (int i = 0; i < 5; i++) begin
         rdc(8'(4 * i), 16'h0000);
         rdc(8'(32 + 4 * i), 16'h0000);
      end
      rdc(8'h80, 16'h4444);
      rdc(8'hFC, 16'h0000);
   endtask : t_reset

   task automatic t_layout;
      for (int i = 0; i < 5; i++) begin
         wr(8'(4 * i), 16'hFFFF);
         rdc(8'(4 * i), LIVE[i]);
         wr(8'(32 + 4 * i), 16'hFFFF);
         rdc(8'(32 + 4 * i), LIVE[i]);
      end
      check(source_req, LIVE_ALL);
      for (int i = 0; i < 5; i++) begin
         wr(8'(32 + 4 * i), 16'h0000);
      end
      @(posedge hclk);
      check(source_req, 80'h0);
      for (int i = 0; i < 5; i++) begin
         wr(8'(4 * i), 16'h0000);
         rdc(8'(4 * i), 16'h0000);
      end
      // Deselected slave must ignore the transfer
      hsel <= 1'b0;
      wr(8'h20, 16'hFFFF);
      hsel <= 1'b1;
      rdc(8'h20, 16'h0000);
   endtask : t_layout

   task automatic t_event;
      wr(8'h28, 16'h4000);
      fork
         evm.fire(46, 1);
         evm.fire(45, 3);
      join_none
      repeat (2) @(posedge hclk);
      check(80'(source_req[46:45]), 80'h2);
      rdc(8'h08, 16'h6000);
      wr(8'hAC, 16'h4044);
      @(posedge hclk);
      check(80'(source_req[46]), 80'h0);
      check(80'(source_prio[140:138]), 80'h0);
      wr(8'hAC, 16'h4444);
      bus(1'b1, 8'h08, 16'h0000, 45);
      rdc(8'h08, 16'h2000);
      wr(8'h08, 16'h0000);
      wr(8'h28, 16'h0000);
   endtask : t_event

   task automatic t_irq;
      wr(8'h30, 16'h0002);
      wr(8'h44, 16'h0010);
      fork
         evm.fire(65, 1);
      join_none
      repeat (2) @(posedge hclk);
      check(80'(irq), 80'h1);
      // Bank 2 summary bit is still sticky from the event scenario
      rdc(8'h40, 16'h0014);
      wr(8'h44, 16'h0000);
      @(posedge hclk);
      check(80'(irq), 80'h0);
      wr(8'h44, 16'h0010);
      @(posedge hclk);
      check(80'(irq), 80'h1);
      wr(8'h40, 16'h0010);
      @(posedge hclk);
      check(80'(irq), 80'h0);
      rdc(8'h40, 16'h0004);
      wr(8'h10, 16'h0000);
   endtask : t_irq

   // Variant changes only under reset
   task automatic t_can;
      can_present <= 1'b0;
      do_reset;
      wr(8'h08, 16'hFFFF);
      rdc(8'h08, 16'h6013);
      wr(8'h10, 16'hFFFF);
      rdc(8'h10, 16'h003E);
      wr(8'h28, 16'hFFFF);
      fork
         evm.fire(34, 1);
      join_none
      repeat (2) @(posedge hclk);
      check(80'(source_req[35:34]), 80'h0);
      can_present <= 1'b1;
      do_reset;
      rdc(8'h08, 16'h0000);
      rdc(8'h28, 16'h0000);
   endtask : t_can

   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : complete_run

   initial begin
      repeat (5000) @(posedge hclk);
      fails++;
      complete_run;
   end

   initial begin
      hresetn = 1'b0;
      hsel = 1'b1;
      hwrite = 1'b0;
      can_present = 1'b1;
      htrans = 2'h0;
      haddr = 32'h00000000;
      hwdata = 32'h00000000;
      fails = 0;
      total_checks = 0;
      do_reset;
      t_reset;
      t_layout;
      t_event;
      t_irq;
      t_can;
      complete_run;
   end
endmodule : test_interrupt_flag_enable_bank

// *** logic/bank_if.sv ***
`timescale 1ns/1ps
interface bank_if;
   irq_bank_pkg::bank_word_t live_mask;
   irq_bank_pkg::bank_word_t wdata;
   logic                     flag_wr;
   logic                     en_wr;
   irq_bank_pkg::bank_word_t set;
   irq_bank_pkg::bank_word_t flag;
   irq_bank_pkg::bank_word_t enable;
   irq_bank_pkg::bank_word_t req;
   logic                     new_req;

   modport bank (
      input  live_mask,
      input  wdata,
      input  flag_wr,
      input  en_wr,
      input  set,
      output flag,
      output enable,
      output req,
      output new_req
   );

   modport ctrl (
      output live_mask,
      output wdata,
      output flag_wr,
      output en_wr,
      output set,
      input  flag,
      input  enable,
      input  req,
      input  new_req
   );
endinterface : bank_if

// *** logic/flag_bank.sv ***
`timescale 1ns/1ps
`include "irq_bank_defines.svh"

module flag_bank (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Bank port
   bank_if.bank     b
);

   irq_bank_pkg::bank_word_t flag_q;
   irq_bank_pkg::bank_word_t flag_d;
   irq_bank_pkg::bank_word_t en_q;
   irq_bank_pkg::bank_word_t en_d;
   irq_bank_pkg::bank_word_t hit;

   always_comb begin
      // Gated sources never latch a set event
      hit    = b.set & b.live_mask;
      flag_d = flag_q;
      if (b.flag_wr) begin
         flag_d = b.wdata;
      end
      // Set applied after the write, so a same-cycle event survives
      flag_d = (flag_d | hit) & b.live_mask;
      en_d   = en_q;
      if (b.en_wr) begin
         en_d = b.wdata & b.live_mask;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flag_q <= `FLAG_RESET;
         en_q   <= `EN_RESET;
      end else begin
         flag_q <= flag_d;
         en_q   <= en_d;
      end
   end

   assign b.flag    = flag_q;
   assign b.enable  = en_q;
   assign b.req     = flag_q & en_q;
   assign b.new_req = |(hit & en_q & ~flag_q);

endmodule : flag_bank

// *** logic/irq_bank_defines.svh ***
`ifndef IRQ_BANK_DEFINES_SVH
`define IRQ_BANK_DEFINES_SVH

// Bank geometry
`define BANK_COUNT     5
`define BANK_W         16
`define SRC_COUNT      80
`define PRIO_W         3
`define PRIO_WORDS     20
`define PRIO_PER_WORD  4

// Word indices, byte address is four times the index
`define IDX_W          6
`define IDX_FLAGS_BASE 6'h00
`define IDX_EN_BASE    6'h08
`define IDX_STATUS     6'h10
`define IDX_MASK       6'h11
`define IDX_PRIO_BASE  6'h20
`define HADDR_IDX_LSB  2

// Implemented positions per bank
`define IMPL_BANK0     16'h7FFF
`define IMPL_BANK1     16'hFFDF
`define IMPL_BANK2     16'h601F
`define IMPL_BANK3     16'h6000
`define IMPL_BANK4     16'h007E

// Positions owned by the CAN controller
`define CAN_BANK2      16'h000C
`define CAN_BANK4      16'h0040
`define NO_BITS        16'h0000

// Reset values
`define FLAG_RESET     16'h0000
`define EN_RESET       16'h0000
`define PRIO_RESET     3'h4
`define PRIO_OFF       3'h0
`define SUM_RESET      5'h00

// Bus constants
`define HTRANS_NONSEQ_BIT 1
`define HRESP_OKAY     1'h0

`endif

// *** logic/irq_bank_pkg.sv ***
package irq_bank_pkg;

   // Bus slave data-phase states, one-hot
   typedef enum logic [3:0] {
      S_IDLE  = 4'h1,
      S_WRITE = 4'h2,
      S_RD1   = 4'h4,
      S_RD2   = 4'h8
   } bus_state_t;

   typedef logic [15:0] bank_word_t;

endpackage : irq_bank_pkg

// *** logic/irq_flag_enable_bank.sv ***
// Implementation choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "irq_bank_defines.svh"

// Behaviour
// - Flags 1 bits 2..0: comparator, I2C master, slave
// - Flags 2: DMA4, parallel port, DMA3..SPI2 error
// - Flags 3: calendar bit 14, DMA5 bit 13 only
// - Flags 4 bits 6..1: CAN tx to UART-A error
// - Flag reads pending request; software writes directly
// - Enable bit one passes request, zero blocks
// - Unimplemented flag and enable bits read zero
// - Without CAN, CAN sources never request
// - Enables 0 bits 14..0, bit 15 unimplemented
// - Enables 2 mirror flags 2 layout
// - Reset clears every flag and enable bit
// - Flags 1 upper bits: UART-B down to capture G
// - Three-bit priority per source, zero blocks source_req but not summary status
// - Flags 0 share enables 0 bit order
module irq_flag_enable_bank (
   // Clock and reset
   input  wire logic                      hclk,
   input  wire logic                      hresetn,
   // AHB-Lite slave
   input  wire logic                      hsel,
   input  wire logic [31:0]               haddr,
   input  wire logic [1:0]                htrans,
   input  wire logic                      hwrite,
   input  wire logic [2:0]                hsize,
   input  wire logic [31:0]               hwdata,
   input  wire logic                      hready,
   output      logic                      hreadyout,
   output      logic [31:0]               hrdata,
   output      logic                      hresp,
   // Device variant
   input  wire logic                      can_present,
   // Peripheral events, one per flag position
   input  wire logic [`SRC_COUNT-1:0]     source_events,
   // Toward priority arbitration
   output      logic [`SRC_COUNT-1:0]     source_req,
   output      logic [`SRC_COUNT*`PRIO_W-1:0] source_prio,
   // Summary interrupt
   output      logic                      irq
);

   irq_bank_pkg::bus_state_t   state_q;
   irq_bank_pkg::bus_state_t   state_d;
   logic [`IDX_W-1:0]          idx_q;
   logic [`IDX_W-1:0]          idx_d;
   logic [31:0]                rdata_q;
   logic [31:0]                rdata_d;
   logic                       take;
   logic                       wr_now;
   logic [15:0]                rd_word;
   logic [15:0]                wdata;

   logic [`BANK_W-1:0]         flag_all [`BANK_COUNT];
   logic [`BANK_W-1:0]         en_all   [`BANK_COUNT];
   logic [`BANK_W-1:0]         req_all  [`BANK_COUNT];
   logic [`BANK_COUNT-1:0]     new_req;

   logic [`PRIO_W-1:0]         prio_q [`SRC_COUNT];
   logic [`PRIO_W-1:0]         prio_d [`SRC_COUNT];

   logic [`BANK_COUNT-1:0]     sum_q;
   logic [`BANK_COUNT-1:0]     sum_d;
   logic [`BANK_COUNT-1:0]     mask_q;
   logic [`BANK_COUNT-1:0]     mask_d;

   function automatic logic [15:0] impl_of(input int unsigned n);
      logic [15:0] m;
      m = `IMPL_BANK0;
      case (n)
         1: m = `IMPL_BANK1;
         2: m = `IMPL_BANK2;
         3: m = `IMPL_BANK3;
         4: m = `IMPL_BANK4;
         default: m = `IMPL_BANK0;
      endcase
      return m;
   endfunction : impl_of

   function automatic logic [15:0] can_of(input int unsigned n);
      logic [15:0] m;
      m = `NO_BITS;
      if (n == 2) begin
         m = `CAN_BANK2;
      end else if (n == 4) begin
         m = `CAN_BANK4;
      end
      return m;
   endfunction : can_of

   // Bus slave: writes one cycle, reads add a wait state
   assign take   = hsel & htrans[`HTRANS_NONSEQ_BIT] & hready;
   assign wr_now = (state_q == irq_bank_pkg::S_WRITE);
   assign wdata  = hwdata[15:0];

   always_comb begin
      state_d = state_q;
      idx_d   = idx_q;
      rdata_d = rdata_q;
      unique case (state_q)
         irq_bank_pkg::S_IDLE,
         irq_bank_pkg::S_WRITE,
         irq_bank_pkg::S_RD2: begin
            state_d = irq_bank_pkg::S_IDLE;
            if (take) begin
               idx_d   = haddr[`HADDR_IDX_LSB +: `IDX_W];
               state_d = hwrite ? irq_bank_pkg::S_WRITE
                                : irq_bank_pkg::S_RD1;
            end
         end
         irq_bank_pkg::S_RD1: begin
            // Sampled after any preceding write has landed
            rdata_d = {16'h0000, rd_word};
            state_d = irq_bank_pkg::S_RD2;
         end
         default: begin
            state_d = irq_bank_pkg::S_IDLE;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q <= irq_bank_pkg::S_IDLE;
         idx_q   <= '0;
         rdata_q <= 32'h00000000;
      end else begin
         state_q <= state_d;
         idx_q   <= idx_d;
         rdata_q <= rdata_d;
      end
   end

   assign hreadyout = (state_q != irq_bank_pkg::S_RD1);
   assign hrdata    = rdata_q;
   assign hresp     = `HRESP_OKAY;

   // Flag and enable banks
   genvar gi;
   generate
      for (gi = 0; gi < `BANK_COUNT; gi++) begin : g_bank
         bank_if u_if ();
         logic [15:0] live;

         // CAN positions vanish on variants without the controller
         assign live = impl_of(gi) &
                       ~(can_present ? `NO_BITS : can_of(gi));
         assign u_if.live_mask = live;
         assign u_if.wdata     = wdata;
         assign u_if.flag_wr   = wr_now &
                                 (idx_q == `IDX_FLAGS_BASE + gi);
         assign u_if.en_wr     = wr_now &
                                 (idx_q == `IDX_EN_BASE + gi);
         assign u_if.set       = source_events[gi*`BANK_W +: `BANK_W];

         flag_bank u_bank (
            .hclk    (hclk),
            .hresetn (hresetn),
            .b       (u_if.bank)
         );

         assign flag_all[gi] = u_if.flag;
         assign en_all[gi]   = u_if.enable;
         assign req_all[gi]  = u_if.req;
         assign new_req[gi]  = u_if.new_req;
      end
   endgenerate

   // Priority fields, four sources to a word
   always_comb begin
      for (int s = 0; s < `SRC_COUNT; s++) begin
         prio_d[s] = prio_q[s];
      end
      if (wr_now && idx_q >= `IDX_PRIO_BASE &&
          idx_q < `IDX_PRIO_BASE + `IDX_W'(`PRIO_WORDS)) begin
         for (int j = 0; j < `PRIO_PER_WORD; j++) begin
            prio_d[(int'(idx_q - `IDX_PRIO_BASE)) * `PRIO_PER_WORD + j] =
               wdata[j*`PRIO_PER_WORD +: `PRIO_W];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int s = 0; s < `SRC_COUNT; s++) begin
            prio_q[s] <= `PRIO_RESET;
         end
      end else begin
         for (int s = 0; s < `SRC_COUNT; s++) begin
            prio_q[s] <= prio_d[s];
         end
      end
   end

   // Request vector toward arbitration
   always_comb begin
      for (int s = 0; s < `SRC_COUNT; s++) begin
         // Priority zero silences a source whatever its flag
         source_req[s] = req_all[s / `BANK_W][s % `BANK_W] &
                         (prio_q[s] != `PRIO_OFF);
         source_prio[s*`PRIO_W +: `PRIO_W] = prio_q[s];
      end
   end

   // Summary status per bank, write one to clear, set wins
   always_comb begin
      sum_d  = sum_q;
      mask_d = mask_q;
      if (wr_now && idx_q == `IDX_STATUS) begin
         sum_d = sum_q & ~wdata[`BANK_COUNT-1:0];
      end
      if (wr_now && idx_q == `IDX_MASK) begin
         mask_d = wdata[`BANK_COUNT-1:0];
      end
      sum_d = sum_d | new_req;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sum_q  <= `SUM_RESET;
         mask_q <= `SUM_RESET;
      end else begin
         sum_q  <= sum_d;
         mask_q <= mask_d;
      end
   end

   assign irq = |(sum_q & mask_q);

   // Read mux; unmapped words and empty flag and enable positions read zero
   always_comb begin
      rd_word = 16'h0000;
      for (int n = 0; n < `BANK_COUNT; n++) begin
         if (idx_q == `IDX_FLAGS_BASE + `IDX_W'(n)) begin
            rd_word = flag_all[n];
         end
         if (idx_q == `IDX_EN_BASE + `IDX_W'(n)) begin
            rd_word = en_all[n];
         end
      end
      if (idx_q == `IDX_STATUS) begin
         rd_word = {11'h000, sum_q};
      end
      if (idx_q == `IDX_MASK) begin
         rd_word = {11'h000, mask_q};
      end
      for (int k = 0; k < `PRIO_WORDS; k++) begin
         if (idx_q == `IDX_PRIO_BASE + `IDX_W'(k)) begin
            rd_word = {1'b0, prio_q[k*`PRIO_PER_WORD + 3],
                       1'b0, prio_q[k*`PRIO_PER_WORD + 2],
                       1'b0, prio_q[k*`PRIO_PER_WORD + 1],
                       1'b0, prio_q[k*`PRIO_PER_WORD]};
         end
      end
   end

endmodule : irq_flag_enable_bank
